// file: dv/dsc_regs_assertions.sv
`timescale 1ns/1ns
`include "dsc_consts.svh"
module dsc_chk (
   // clock, reset and register port
   input wire logic       mclk_i, resetn_i, reg_wr_i, reg_rd_i,
   input wire logic [7:0] reg_addr_i, reg_wdata_i,
   // watched outputs and the slot one clock-stop input
   input wire logic       slot_clk_stop_one_i, dir_pin_used_o,
   input wire logic       dir_card_to_bb_o, irq_o, bsi_thr_sel_o,
   input wire logic       slot_one_sig_low_o, slot_one_reg_off_o,
   input wire logic       slot_two_sig_low_o, slot_two_reg_off_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);
   logic cfg_wr;
   assign cfg_wr = reg_wr_i && reg_addr_i == `DSC_OFS_CFG;
   dir_unused_a: assert property (
      !dir_pin_used_o |-> !dir_card_to_bb_o)
      else $error("direction set with pin unused");
   dir_enable_a: assert property (cfg_wr |-> ##2
      dir_pin_used_o == $past(reg_wdata_i[0], 2)) else $error("pin use bad");
   thr_select_a: assert property (cfg_wr |-> ##2
      bsi_thr_sel_o == $past(reg_wdata_i[3], 2)) else $error("threshold bad");
   irq_hold_a: assert property (irq_o && !(reg_rd_i &&
      reg_addr_i == `DSC_OFS_STATUS) |=> irq_o) else $error("irq dropped");
   pd_one_sticky_a: assert property (slot_one_reg_off_o |=>
      slot_one_reg_off_o) else $error("slot one back on");
   pd_two_sticky_a: assert property (slot_two_reg_off_o |=>
      slot_two_reg_off_o) else $error("slot two back on");
   off_after_low_a: assert property (slot_two_reg_off_o |->
      slot_two_sig_low_o) else $error("regulator off, signals not low");
   stop_order_a: assert property ($rose(slot_one_sig_low_o) &&
      slot_clk_stop_one_i |-> !slot_one_reg_off_o) else $error("early off");
   reset_clear_a: assert property (disable iff (1'b0)
      !resetn_i |=> !irq_o && !slot_two_reg_off_o)
      else $error("reset left state");
   cover property (cfg_wr);
   cover property ($rose(irq_o));
   cover property ($rose(slot_one_reg_off_o));
endmodule : dsc_chk
bind dsc_regs dsc_chk dsc_chk_i (.mclk_i(mclk_i), .resetn_i(resetn_i),
   .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .slot_clk_stop_one_i(slot_clk_stop_one_i),
   .dir_pin_used_o(dir_pin_used_o), .dir_card_to_bb_o(dir_card_to_bb_o),
   .irq_o(irq_o), .bsi_thr_sel_o(bsi_thr_sel_o),
   .slot_one_sig_low_o(slot_one_sig_low_o),
   .slot_one_reg_off_o(slot_one_reg_off_o),
   .slot_two_sig_low_o(slot_two_sig_low_o),
   .slot_two_reg_off_o(slot_two_reg_off_o));

// file: dv/dsc_tick_src.sv
`timescale 1ns/1ns
module dsc_tick_src #(parameter int PERIOD = 20) (
   // clock and enables
   input  wire logic mclk_i,
   input  wire logic int_en_i,
   input  wire logic ext_en_i,
   // tick pulses
   output logic      int_tick_o,
   output logic      ext_tick_o
);
   int cnt = 0;
   // ext phase offset so the sources never pulse together
   always @(posedge mclk_i) begin
      cnt        <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      int_tick_o <= int_en_i && cnt == 0;
      ext_tick_o <= ext_en_i && cnt == PERIOD / 2;
   end
endmodule : dsc_tick_src

// file: dv/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   logic        mclk_i = 0, resetn_i = 0, wr_s = 0, rd_s = 0, slot_two_shutdown_input = 1;
   logic        blo = 0, bhi = 0, pin = 0, cs1 = 1, ie = 1, ee = 1;
   logic [7:0]  addr = 8'h00, wd = 8'h00, rdat;
   logic        itk, etk, thr, c2b, used, irq, lo1, lo2, off1, off2;
   int          err_count = 0, checks = 0, i, j;
   logic [23:0] rows [8] = '{24'h0A_0000, 24'h0A_FFFF, 24'h0B_0000,
      24'h0B_A5A5, 24'h0D_7F7F, 24'h0D_8080, 24'h0E_5A5A, 24'h20_FF00};
   always #20 mclk_i = ~mclk_i;
   dsc_tick_src dsc_tick_src_i (.mclk_i(mclk_i), .int_en_i(ie),
      .ext_en_i(ee), .int_tick_o(itk), .ext_tick_o(etk));
   dsc_regs dsc_regs_i (.mclk_i(mclk_i), .resetn_i(resetn_i),
      .reg_addr_i(addr), .reg_wr_i(wr_s), .reg_wdata_i(wd),
      .reg_rd_i(rd_s), .reg_rdata_o(rdat), .int_tick_i(itk),
      .ext_tick_i(etk), .bsi_above_low_i(blo), .bsi_above_high_i(bhi),
      .slot_two_shutdown_input_i(slot_two_shutdown_input), .dir_pin_i(pin),
      .slot_clk_stop_one_i(cs1), .slot_clk_stop_two_i(1'b0),
      .bsi_thr_sel_o(thr), .dir_card_to_bb_o(c2b), .dir_pin_used_o(used),
      .irq_o(irq), .slot_one_sig_low_o(lo1), .slot_two_sig_low_o(lo2),
      .slot_one_reg_off_o(off1), .slot_two_reg_off_o(off2));
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      addr <= a;
      wd   <= d;
      wr_s <= 1'b1;
      @(posedge mclk_i);
      wr_s <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge mclk_i);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge mclk_i);
      rd_s <= 1'b0;
      @(negedge mclk_i);
      chk(rdat, exp);
   endtask : rd
   task rst;
      @(posedge mclk_i);
      resetn_i <= 1'b0;
      repeat (6) @(posedge mclk_i);
      resetn_i <= 1'b1;
   endtask : rst
   task print_verdict;
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : print_verdict
   initial begin
      #3000000;
      err_count++;
      print_verdict;
   end
   initial begin
      rst;
      rd(8'h0A, 8'h04);
      rd(8'h0B, 8'h04);
      rd(8'h0D, 8'h00);
      rd(8'h0E, 8'h00);
      for (i = 0; i < 8; i++) begin
         wr(rows[i][23:16], rows[i][15:8]);
         rd(rows[i][23:16], rows[i][7:0]);
      end
      rst;
      // pin level, polarity and enable in all combinations
      for (j = 0; j < 8; j++) begin
         @(posedge mclk_i);
         pin <= j[2];
         wr(8'h0E, {6'h00, j[1:0]});
         repeat (3) @(negedge mclk_i);
         chk({7'h00, c2b}, {7'h00, j[0] & (j[2] ^ j[1])});
         chk({7'h00, used}, {7'h00, j[0]});
      end
      wr(8'h0A, 8'h03);
      wr(8'h0E, 8'h0C);
      repeat (2) @(negedge mclk_i);
      chk({7'h00, thr}, 8'h01);
      @(posedge mclk_i);
      blo <= 1'b1;
      repeat (100) @(negedge mclk_i);
      chk({7'h00, irq}, 8'h00);
      @(posedge mclk_i);
      bhi <= 1'b1;
      repeat (25) @(negedge mclk_i);
      chk({7'h00, irq}, 8'h00);
      for (i = 0; i < 200 && lo1 !== 1'b1; i++) @(negedge mclk_i);
      chk({7'h00, off1}, 8'h00);
      for (i = 0; i < 40 && off1 !== 1'b1; i++) @(negedge mclk_i);
      chk({4'h0, lo1, lo2, off1, off2}, 8'h0F);
      chk({7'h00, irq}, 8'h01);
      @(posedge mclk_i);
      blo <= 1'b0;
      bhi <= 1'b0;
      rd(8'h04, 8'h08);
      repeat (2) @(negedge mclk_i);
      chk({7'h00, irq}, 8'h00);
      rst;
      // rewrite while counting restarts with the short count
      wr(8'h0E, 8'h04);
      wr(8'h0A, 8'h08);
      blo <= 1'b1;
      repeat (40) @(posedge mclk_i);
      wr(8'h0A, 8'h01);
      repeat (2) @(negedge mclk_i);
      chk({7'h00, irq}, 8'h00);
      repeat (80) @(negedge mclk_i);
      chk({7'h00, irq}, 8'h01);
      @(posedge mclk_i);
      blo <= 1'b0;
      rst;
      // zero count: detection on the first tick
      wr(8'h0E, 8'h04);
      wr(8'h0A, 8'h00);
      blo <= 1'b1;
      repeat (25) @(negedge mclk_i);
      chk({7'h00, irq}, 8'h01);
      @(posedge mclk_i);
      blo <= 1'b0;
      rst;
      // external source chosen but stopped: no detection may happen
      ee <= 1'b0;
      wr(8'h0D, 8'h80);
      wr(8'h0B, 8'h02);
      wr(8'h0E, 8'h60);
      repeat (100) @(negedge mclk_i);
      chk({7'h00, irq}, 8'h00);
      @(posedge mclk_i);
      ee <= 1'b1;
      for (i = 0; i < 200 && off2 !== 1'b1; i++) @(negedge mclk_i);
      chk({4'h0, lo1, lo2, off1, off2}, 8'h05);
      chk({7'h00, irq}, 8'h01);
      @(posedge mclk_i);
      slot_two_shutdown_input <= 1'b0;
      rd(8'h04, 8'h02);
      print_verdict;
   end
endmodule : tb_top

// file: hdl/dsc_consts.svh
`ifndef DSC_CONSTS_SVH
`define DSC_CONSTS_SVH
`define DSC_OFS_BSI_CNT   8'h0A
`define DSC_OFS_SDN_CNT   8'h0B
`define DSC_OFS_CLK_SEL   8'h0D
`define DSC_OFS_CFG       8'h0E
`define DSC_OFS_STATUS    8'h04
`define DSC_RST_CNT       8'h04
`define DSC_RST_CLK_SEL   8'h00
`define DSC_RST_CFG       8'h00
`define DSC_BIT_CLK_SRC   7
`define DSC_BIT_DIR_EN    0
`define DSC_BIT_DIR_POL   1
`define DSC_BIT_BSI_IRQ   2
`define DSC_BIT_BSI_THR   3
`define DSC_BIT_BSI_NOPD  4
`define DSC_BIT_SDN_IRQ   5
`define DSC_BIT_SDN_LVL   6
`define DSC_BIT_SDN_NOPD  7
`define DSC_ST_BSI        3
`define DSC_ST_SDN        1
`endif

// file: hdl/dsc_debounce.sv
`timescale 1ns/1ns
`include "dsc_consts.svh"
module dsc_debounce (
   // clock and reset
   input  wire logic       mclk_i,
   input  wire logic       resetn_i,
   // timing tick and control
   input  wire logic       tick_i,
   input  wire logic       active_i,
   input  wire logic [7:0] count_i,
   input  wire logic       reload_i,
   // result
   output logic            detect_o,
   output logic            expire_o
);
   typedef struct packed {
      dsc_pkg::dsc_deb_st_t st;
      logic [7:0]           cnt;
      logic                 pend;
      logic                 exp;
   } dsc_deb_t;
   dsc_deb_t r;
   dsc_deb_t next_r;

   always_comb begin
      next_r = r;
      next_r.exp = 1'b0;
      if (reload_i) begin
         next_r.pend = 1'b1;
      end
      if (!active_i) begin
         next_r.st = dsc_pkg::DSC_IDLE;
      end else if (tick_i) begin
         unique case (r.st)
            dsc_pkg::DSC_IDLE: begin
               if (count_i == 8'h00) begin
                  next_r.st  = dsc_pkg::DSC_DET;
                  next_r.exp = 1'b1;
               end else begin
                  next_r.st  = dsc_pkg::DSC_CNT;
                  next_r.cnt = count_i - 8'h01;
               end
               // a strobe in this cycle still sees the old count_i
               next_r.pend = reload_i;
            end
            dsc_pkg::DSC_CNT: begin
               // restart on a fresh write, applied at the next tick
               if (r.pend) begin
                  next_r.cnt  = count_i;
                  next_r.pend = reload_i;
               end else if (r.cnt == 8'h00) begin
                  next_r.st  = dsc_pkg::DSC_DET;
                  next_r.exp = 1'b1;
               end else begin
                  next_r.cnt = r.cnt - 8'h01;
               end
            end
            dsc_pkg::DSC_DET: begin
               next_r.pend = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         r <= '{st: dsc_pkg::DSC_IDLE, cnt: 8'h00, pend: 1'b0, exp: 1'b0};
      end else begin
         r <= next_r;
      end
   end

   assign detect_o = (r.st == dsc_pkg::DSC_DET);
   assign expire_o = r.exp;
endmodule : dsc_debounce

// file: hdl/dsc_pkg.sv
package dsc_pkg;
   typedef enum logic [2:0] {
      DSC_IDLE = 3'b001,
      DSC_CNT  = 3'b010,
      DSC_DET  = 3'b100
   } dsc_deb_st_t;
   typedef enum logic [2:0] {
      DSC_ON   = 3'b001,
      DSC_LOW  = 3'b010,
      DSC_OFF  = 3'b100
   } dsc_pd_st_t;
endpackage : dsc_pkg

// file: hdl/dsc_regs.sv
`timescale 1ns/1ns
`include "dsc_consts.svh"
module dsc_regs (
   // clock and reset
   input  wire logic       mclk_i,
   input  wire logic       resetn_i,
   // register port
   input  wire logic [7:0] reg_addr_i,
   input  wire logic       reg_wr_i,
   input  wire logic [7:0] reg_wdata_i,
   input  wire logic       reg_rd_i,
   output logic [7:0]      reg_rdata_o,
   // timing clocks, one-cycle pulses at 32 kHz rate
   input  wire logic       int_tick_i,
   input  wire logic       ext_tick_i,
   // sensed inputs
   input  wire logic       bsi_above_low_i,
   input  wire logic       bsi_above_high_i,
   input  wire logic       slot_two_shutdown_input_i,
   // direction pin and slot clock-stop inputs
   input  wire logic       dir_pin_i,
   input  wire logic       slot_clk_stop_one_i,
   input  wire logic       slot_clk_stop_two_i,
   // outputs
   output logic            bsi_thr_sel_o,
   output logic            dir_card_to_bb_o,
   output logic            dir_pin_used_o,
   output logic            irq_o,
   output logic            slot_one_sig_low_o,
   output logic            slot_two_sig_low_o,
   output logic            slot_one_reg_off_o,
   output logic            slot_two_reg_off_o
);
   typedef struct packed {
      logic [7:0]          bsi_cnt;
      logic [7:0]          sdn_cnt;
      logic [7:0]          clk_sel;
      logic [7:0]          cfg;
      logic [7:0]          status;
      logic [7:0]          rdata;
      logic                irq;
      logic                dir_c2b;
      logic                dir_used;
      logic                thr;
      dsc_pkg::dsc_pd_st_t pd1;
      dsc_pkg::dsc_pd_st_t pd2;
      logic                lo1;
      logic                lo2;
      logic                off1;
      logic                off2;
   } dsc_regs_t;
   dsc_regs_t r;
   dsc_regs_t next_r;
   logic tick;
   logic bsi_active;
   logic sdn_active;
   logic bsi_det;
   logic sdn_det;
   logic bsi_exp;
   logic sdn_exp;
   logic wr_bsi;
   logic wr_sdn;
   logic bsi_pd_req;
   logic sdn_pd_req;

   // decode shared by both reload strobes
   function automatic logic is_wr(
      input logic       wr,
      input logic [7:0] addr,
      input logic [7:0] ofs);
      is_wr = wr && (addr == ofs);
   endfunction : is_wr

   function automatic dsc_pkg::dsc_pd_st_t pd_step(
      input dsc_pkg::dsc_pd_st_t cur,
      input logic                trig,
      input logic                clk_stop,
      input logic                tk);
      pd_step = cur;
      unique case (cur)
         dsc_pkg::DSC_ON: begin
            if (trig) begin
               // active slots take the same path; LOW ends on a tick or a running clock
               pd_step = dsc_pkg::DSC_LOW;
            end
         end
         dsc_pkg::DSC_LOW: begin
            if (tk || !clk_stop) begin
               pd_step = dsc_pkg::DSC_OFF;
            end
         end
         dsc_pkg::DSC_OFF: begin
            pd_step = cur;
         end
      endcase
   endfunction : pd_step

   function automatic logic [7:0] rd_mux(
      input dsc_regs_t  cur,
      input logic [7:0] addr);
      unique case (addr)
         `DSC_OFS_BSI_CNT: rd_mux = cur.bsi_cnt;
         `DSC_OFS_SDN_CNT: rd_mux = cur.sdn_cnt;
         `DSC_OFS_CLK_SEL: rd_mux = cur.clk_sel;
         `DSC_OFS_CFG:     rd_mux = cur.cfg;
         `DSC_OFS_STATUS:  rd_mux = cur.status;
         default:          rd_mux = 8'h00;
      endcase
   endfunction : rd_mux

   // tick follows the selected timing clock
   assign tick = r.clk_sel[`DSC_BIT_CLK_SRC] ? ext_tick_i
                                             : int_tick_i;
   // comparator output is above the selected threshold
   assign bsi_active = r.cfg[`DSC_BIT_BSI_THR] ? bsi_above_high_i
                                               : bsi_above_low_i;
   assign sdn_active = r.cfg[`DSC_BIT_SDN_LVL] ? slot_two_shutdown_input_i
                       : !slot_two_shutdown_input_i;
   assign wr_bsi = is_wr(reg_wr_i, reg_addr_i, `DSC_OFS_BSI_CNT);
   assign wr_sdn = is_wr(reg_wr_i, reg_addr_i, `DSC_OFS_SDN_CNT);
   // battery loss drops both slots, shutdown pin only slot two
   assign bsi_pd_req = bsi_det && !r.cfg[`DSC_BIT_BSI_NOPD];
   assign sdn_pd_req = sdn_det && !r.cfg[`DSC_BIT_SDN_NOPD];

   // one debouncer per sensed input, both on the selected tick
   dsc_debounce u_bsi (
      .mclk_i   (mclk_i),
      .resetn_i (resetn_i),
      .tick_i   (tick),
      .active_i (bsi_active),
      .count_i  (r.bsi_cnt),
      .reload_i (wr_bsi),
      .detect_o (bsi_det),
      .expire_o (bsi_exp)
   );

   dsc_debounce u_sdn (
      .mclk_i   (mclk_i),
      .resetn_i (resetn_i),
      .tick_i   (tick),
      .active_i (sdn_active),
      .count_i  (r.sdn_cnt),
      .reload_i (wr_sdn),
      .detect_o (sdn_det),
      .expire_o (sdn_exp)
   );

   always_comb begin
      next_r = r;
      if (reg_wr_i) begin
         unique case (reg_addr_i)
            `DSC_OFS_BSI_CNT: next_r.bsi_cnt = reg_wdata_i;
            `DSC_OFS_SDN_CNT: next_r.sdn_cnt = reg_wdata_i;
            `DSC_OFS_CLK_SEL: next_r.clk_sel = reg_wdata_i;
            `DSC_OFS_CFG:     next_r.cfg     = reg_wdata_i;
            default: begin
               next_r.cfg = r.cfg;
            end
         endcase
      end
      // status is read-to-clear; a new event in that cycle still wins
      if (reg_rd_i && reg_addr_i == `DSC_OFS_STATUS) begin
         next_r.status = 8'h00;
      end
      if (bsi_exp && r.cfg[`DSC_BIT_BSI_IRQ]) begin
         next_r.status[`DSC_ST_BSI] = 1'b1;
      end
      if (sdn_exp && r.cfg[`DSC_BIT_SDN_IRQ]) begin
         next_r.status[`DSC_ST_SDN] = 1'b1;
      end
      next_r.irq = |next_r.status;
      // unmapped offsets read as zero
      next_r.rdata = rd_mux(r, reg_addr_i);
      next_r.dir_used = r.cfg[`DSC_BIT_DIR_EN];
      // bit clear: pin high means card to baseband
      next_r.dir_c2b = r.cfg[`DSC_BIT_DIR_EN] &&
                       (dir_pin_i ^ r.cfg[`DSC_BIT_DIR_POL]);
      next_r.thr = r.cfg[`DSC_BIT_BSI_THR];
      next_r.pd1 = pd_step(r.pd1, bsi_pd_req, slot_clk_stop_one_i, tick);
      next_r.pd2 = pd_step(r.pd2, bsi_pd_req || sdn_pd_req,
                           slot_clk_stop_two_i, tick);
      // outputs registered straight from the next state
      next_r.lo1  = (next_r.pd1 != dsc_pkg::DSC_ON);
      next_r.lo2  = (next_r.pd2 != dsc_pkg::DSC_ON);
      next_r.off1 = (next_r.pd1 == dsc_pkg::DSC_OFF);
      next_r.off2 = (next_r.pd2 == dsc_pkg::DSC_OFF);
   end

   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         r <= '{bsi_cnt:  `DSC_RST_CNT,
                sdn_cnt:  `DSC_RST_CNT,
                clk_sel:  `DSC_RST_CLK_SEL,
                cfg:      `DSC_RST_CFG,
                status:   8'h00,
                rdata:    8'h00,
                irq:      1'b0,
                dir_c2b:  1'b0,
                dir_used: 1'b0,
                thr:      1'b0,
                pd1:      dsc_pkg::DSC_ON,
                pd2:      dsc_pkg::DSC_ON,
                lo1:      1'b0,
                lo2:      1'b0,
                off1:     1'b0,
                off2:     1'b0};
      end else begin
         r <= next_r;
      end
   end

   assign reg_rdata_o        = r.rdata;
   assign irq_o              = r.irq;
   assign bsi_thr_sel_o      = r.thr;
   assign dir_card_to_bb_o   = r.dir_c2b;
   assign dir_pin_used_o     = r.dir_used;
   assign slot_one_sig_low_o = r.lo1;
   assign slot_two_sig_low_o = r.lo2;
   assign slot_one_reg_off_o = r.off1;
   assign slot_two_reg_off_o = r.off2;
endmodule : dsc_regs
